// *** include/fpt_pkg.sv ***
// Package with register map, field positions, reset values and codes for the fast PWM timer.
//
// Overview of operation
// - Clear-on-match set: counter returns to zero the cycle after compare-A match; it clears only if a tick falls in that cycle, as at /1.
// - PWM enable: PWM on compare A, counter clears after match with top; it clears only if a tick falls in the next cycle, as at /1.
// - Non-PWM compare-A action: 00 off, 01 toggle, 10 clear, 11 set.
// - Compare output drives pin only when its port direction bit is one.
// - PWM: 10 clears on match, sets at zero; 11 opposite; others disconnected.
// - Four-bit clock select: stop, fast clock /1../8, cpu clock /1../1024.
// - Force bit applies output action like a match, no interrupt, new mode used.
// - Force bit reads zero and is ignored in PWM mode.
// - Prescaler clear bit resets prescaler only, self clears, reads zero.
// - Counter write lands one cpu clock later, two in fast-clock mode.
// - Match only when counting onto compare value, never from a software write.
// - Compare-A match sets compare-A flag after a synchronisation delay.
// - With clear-on-match set, a match against top also clears the counter; only if a tick falls in the next cycle, as at /1.
// - Compare-A enable and global enable request interrupt vector three.
// - Overflow enable and global enable request interrupt vector four.
// - Compare-A flag clears on vector execution or writing one, after sync.
// - Overflow flag sets on overflow, clears on vector or writing one.
// - Reserved bits of mask, flag and PLL registers read as zero.
// - Compatibility mode forces fast-clock enable and PLL enable to one.
// - Counter is an eight-bit up counter, readable and writable.
// - Overflow flag on FF to 00 wrap; in PWM also top to 00.
// - PWM writes to compare A go to a buffer, loaded at top; reads buffer.
package fpt_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // Register offsets.
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h30;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h38;
    localparam logic [7:0] OFS_GENERAL_CTRL = 8'h2C;
    localparam logic [7:0] OFS_COUNT = 8'h2F;
    localparam logic [7:0] OFS_CMP_A = 8'h2E;
    localparam logic [7:0] OFS_CMP_TOP = 8'h2D;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h39;
    localparam logic [7:0] OFS_PLL_CTRL = 8'h27;
    // Timer control fields.
    localparam int BIT_CLR_ON_MATCH = 7;
    localparam int BIT_PWM_EN = 6;
    localparam int BIT_ACT_HI = 5;
    localparam int BIT_ACT_LO = 4;
    localparam int CS_MSB = 3;
    // General control, mask, flag and PLL fields.
    localparam int BIT_FORCE_A = 2;
    localparam int BIT_PRESC_CLR = 1;
    localparam int BIT_CMP_A = 6;
    localparam int BIT_OVF = 2;
    localparam int BIT_FAST_CLK_EN = 2;
    localparam int BIT_PLL_ON = 1;
    // Reset values.
    localparam logic [7:0] RST_TIMER_CTRL = 8'h00;
    localparam logic [7:0] RST_CMP_A = 8'h00;
    localparam logic [7:0] RST_CMP_TOP = 8'hFF;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    // Clock select codes.
    localparam logic [3:0] CS_STOP = 4'h0;
    localparam logic [3:0] CS_FAST_LAST = 4'h4;
    localparam logic [3:0] CS_CPU_FIRST = 4'h5;
    localparam int PRESC_W = 10;
    // Synchronisation stages between a compare-A match and its flag.
    localparam int FLAG_SYNC_CYC = 1;
    // Output actions.
    typedef enum logic [1:0] {
        FPT_ACT_OFF,
        FPT_ACT_TOGGLE,
        FPT_ACT_CLEAR,
        FPT_ACT_SET
    } fpt_act_t;
endpackage : fpt_pkg

// *** include/fpt_tick_if.sv ***
// Interface carrying the prescaler controls and the counting tick.
`timescale 1ns/1ps
interface fpt_tick_if;
    logic [3:0] clk_source_sel;
    logic fast_mode;
    logic prescaler_clear;
    logic tick;
    modport ctrl (output clk_source_sel, output fast_mode, output prescaler_clear, input tick);
    modport presc (input clk_source_sel, input fast_mode, input prescaler_clear, output tick);
endinterface : fpt_tick_if

// *** rtl/fpt_prescaler.sv ***
// Prescaler that turns the clock select code into a one-cycle counting tick.
`timescale 1ns/1ps
module fpt_prescaler (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic fast_tick_i,
    fpt_tick_if.presc tk
);
    logic [fpt_pkg::PRESC_W-1:0] div_cnt;
    logic [fpt_pkg::PRESC_W:0] tap_mask;
    logic [3:0] shift;
    logic src_tick;
    logic sel_tick;
    // Fast codes divide fast ticks by 1..8, cpu codes divide cpu cycles by 1..1024.
    assign src_tick = tk.fast_mode ? fast_tick_i : 1'b1;
    assign shift = tk.fast_mode ? 4'(tk.clk_source_sel - 4'h1)
                                : 4'(tk.clk_source_sel - fpt_pkg::CS_CPU_FIRST);
    // Mask of the counter bits below the chosen tap; an empty mask ticks on every source tick.
    assign tap_mask = (11'h001 << shift) - 11'h001;
    // Tick when all counter bits below the chosen tap are one.
    assign sel_tick = src_tick
        && ((div_cnt & tap_mask[fpt_pkg::PRESC_W-1:0]) == tap_mask[fpt_pkg::PRESC_W-1:0]);
    // The divider restarts on a prescaler clear so the next period is whole.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || tk.prescaler_clear) begin
            div_cnt <= '0;
        end else if (src_tick && tk.clk_source_sel != fpt_pkg::CS_STOP) begin
            div_cnt <= div_cnt + 10'h001;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tk.tick <= 1'b0;
        end else begin
            tk.tick <= sel_tick && !tk.prescaler_clear && tk.clk_source_sel != fpt_pkg::CS_STOP;
        end
    end
endmodule : fpt_prescaler

// *** rtl/fpt_timer.sv ***
// Top of the fast PWM timer: registers, counter, compare logic and flags.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module fpt_timer (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic fast_tick_i,
    input wire logic compat_mode_i,
    input wire logic port_pin_one_dir_i,
    input wire logic global_irq_en_i,
    input wire logic cmp_a_vec_ack_i,
    input wire logic ovf_vec_ack_i,
    output logic cmp_a_out_pin_o,
    output logic cmp_a_out_pin_oe_o,
    output logic cmp_a_irq_o,
    output logic ovf_irq_o,
    output logic fast_clk_en_o,
    output logic pll_on_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [7:0] timer_ctrl_reg;
    logic [7:0] count_value;
    logic [7:0] cmp_a_value;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_top_value;
    logic cmp_a_irq_en;
    logic ovf_irq_en;
    logic cmp_a_flag;
    logic ovf_flag;
    logic fast_clk_en;
    logic pll_on;
    logic out_level;
    logic count_wr_pend;
    logic count_wr_pend2;
    logic [7:0] count_wr_data;
    logic [fpt_pkg::FLAG_SYNC_CYC-1:0] cmp_a_sync;
    logic cmp_a_clr_pend;
    logic ovf_clr_pend;
    logic cmp_a_hit;
    logic cmp_top_hit;
    logic wrap_pend;
    logic ovf_pend;

    fpt_tick_if tk ();

    fpt_prescaler u_presc (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .fast_tick_i(fast_tick_i),
        .tk(tk)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode and field views.
    logic sel_ctrl, sel_gen, sel_cnt, sel_cmpa, sel_top, sel_mask, sel_flag, sel_pll;
    logic clear_on_match_en, pwm_chan_a_en;
    logic [1:0] out_action_a;
    logic [3:0] clk_source_sel;
    logic fast_mode;
    logic force_wr, presc_wr;
    logic [1:0] act_now;
    logic tick;
    logic [7:0] next_count;
    logic at_top;
    assign sel_ctrl = addr_i == fpt_pkg::OFS_TIMER_CTRL;
    assign sel_gen = addr_i == fpt_pkg::OFS_GENERAL_CTRL;
    assign sel_cnt = addr_i == fpt_pkg::OFS_COUNT;
    assign sel_cmpa = addr_i == fpt_pkg::OFS_CMP_A;
    assign sel_top = addr_i == fpt_pkg::OFS_CMP_TOP;
    assign sel_mask = addr_i == fpt_pkg::OFS_IRQ_MASK;
    assign sel_flag = addr_i == fpt_pkg::OFS_IRQ_FLAG;
    assign sel_pll = addr_i == fpt_pkg::OFS_PLL_CTRL;
    assign clear_on_match_en = timer_ctrl_reg[fpt_pkg::BIT_CLR_ON_MATCH];
    assign pwm_chan_a_en = timer_ctrl_reg[fpt_pkg::BIT_PWM_EN];
    assign out_action_a = timer_ctrl_reg[fpt_pkg::BIT_ACT_HI:fpt_pkg::BIT_ACT_LO];
    assign clk_source_sel = timer_ctrl_reg[fpt_pkg::CS_MSB:0];
    assign fast_mode = clk_source_sel != fpt_pkg::CS_STOP
                       && clk_source_sel <= fpt_pkg::CS_FAST_LAST;
    // A match in the same cycle as a mode write uses the written mode.
    assign force_wr = wr_i && sel_gen && wdata_i[fpt_pkg::BIT_FORCE_A] && !pwm_chan_a_en;
    assign act_now = (wr_i && sel_ctrl) ? wdata_i[fpt_pkg::BIT_ACT_HI:fpt_pkg::BIT_ACT_LO]
                                        : out_action_a;
    assign presc_wr = wr_i && sel_gen && wdata_i[fpt_pkg::BIT_PRESC_CLR];
    assign tick = tk.tick;
    assign tk.clk_source_sel = clk_source_sel;
    assign tk.fast_mode = fast_mode;
    assign tk.prescaler_clear = presc_wr;
    // A wrap from FF always overflows; PWM mode adds the wrap from the top value.
    assign at_top = (count_value == fpt_pkg::COUNT_MAX)
                    || (pwm_chan_a_en && count_value == cmp_top_value);
    assign next_count = 8'(count_value + 8'h01);

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers; compatibility mode pins the clock enables high.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            timer_ctrl_reg <= fpt_pkg::RST_TIMER_CTRL;
            cmp_top_value <= fpt_pkg::RST_CMP_TOP;
            cmp_a_irq_en <= 1'b0;
            ovf_irq_en <= 1'b0;
            fast_clk_en <= 1'b0;
            pll_on <= 1'b0;
        end else begin
            if (wr_i && sel_ctrl) timer_ctrl_reg <= wdata_i;
            if (wr_i && sel_top) cmp_top_value <= wdata_i;
            if (wr_i && sel_mask) begin
                cmp_a_irq_en <= wdata_i[fpt_pkg::BIT_CMP_A];
                ovf_irq_en <= wdata_i[fpt_pkg::BIT_OVF];
            end
            if (compat_mode_i) begin
                fast_clk_en <= 1'b1;
                pll_on <= 1'b1;
            end else if (wr_i && sel_pll) begin
                fast_clk_en <= wdata_i[fpt_pkg::BIT_FAST_CLK_EN];
                pll_on <= wdata_i[fpt_pkg::BIT_PLL_ON];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare A: direct in normal mode, buffered until top in PWM mode.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cmp_a_buf <= fpt_pkg::RST_CMP_A;
            cmp_a_value <= fpt_pkg::RST_CMP_A;
        end else begin
            if (wr_i && sel_cmpa) cmp_a_buf <= wdata_i;
            if (wr_i && sel_cmpa && !pwm_chan_a_en) begin
                cmp_a_value <= wdata_i;
            end else if (pwm_chan_a_en && tick && count_value == cmp_top_value) begin
                cmp_a_value <= cmp_a_buf;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counter. Matches are judged on the value the counter counted onto, so
    // a software write that lands on a compare value raises nothing.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            count_value <= fpt_pkg::RST_COUNT;
            count_wr_pend <= 1'b0;
            count_wr_pend2 <= 1'b0;
            count_wr_data <= fpt_pkg::RST_COUNT;
            cmp_a_hit <= 1'b0;
            cmp_top_hit <= 1'b0;
            wrap_pend <= 1'b0;
        end else begin
            // Fast-clock mode adds one stage so the write lands within two cycles.
            count_wr_pend <= wr_i && sel_cnt;
            count_wr_pend2 <= count_wr_pend && fast_mode;
            if (wr_i && sel_cnt) count_wr_data <= wdata_i;
            cmp_a_hit <= 1'b0;
            cmp_top_hit <= 1'b0;
            wrap_pend <= 1'b0;
            if ((count_wr_pend && !fast_mode) || count_wr_pend2) begin
                count_value <= count_wr_data;
            end else if (tick) begin
                if ((clear_on_match_en && (cmp_a_hit || cmp_top_hit))
                    || (pwm_chan_a_en && cmp_top_hit)) begin
                    count_value <= 8'h00;
                end else begin
                    count_value <= next_count;
                    cmp_a_hit <= next_count == cmp_a_value;
                    cmp_top_hit <= next_count == cmp_top_value;
                end
                wrap_pend <= at_top;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output compare pin.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            out_level <= 1'b0;
        end else if (pwm_chan_a_en) begin
            if (cmp_a_hit && act_now[1]) begin
                out_level <= act_now[0];
            end else if (tick && count_value == 8'h00 && act_now[1]) begin
                out_level <= !act_now[0];
            end
        end else if (cmp_a_hit || force_wr) begin
            unique case (fpt_pkg::fpt_act_t'(act_now))
                fpt_pkg::FPT_ACT_OFF: out_level <= out_level;
                fpt_pkg::FPT_ACT_TOGGLE: out_level <= !out_level;
                fpt_pkg::FPT_ACT_CLEAR: out_level <= 1'b0;
                fpt_pkg::FPT_ACT_SET: out_level <= 1'b1;
            endcase
        end
    end

    // The pin follows the compare logic only when its direction bit is set.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cmp_a_out_pin_o <= 1'b0;
            cmp_a_out_pin_oe_o <= 1'b0;
        end else begin
            cmp_a_out_pin_o <= out_level;
            cmp_a_out_pin_oe_o <= port_pin_one_dir_i
                && (pwm_chan_a_en ? out_action_a[1] : out_action_a != 2'b00);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags: set wins over a clear arriving in the same cycle.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cmp_a_sync <= '0;
            cmp_a_flag <= 1'b0;
            ovf_flag <= 1'b0;
            ovf_pend <= 1'b0;
            cmp_a_clr_pend <= 1'b0;
            ovf_clr_pend <= 1'b0;
        end else begin
            cmp_a_sync <= fpt_pkg::FLAG_SYNC_CYC'(cmp_a_hit);
            ovf_pend <= wrap_pend;
            cmp_a_clr_pend <= wr_i && sel_flag && wdata_i[fpt_pkg::BIT_CMP_A];
            ovf_clr_pend <= wr_i && sel_flag && wdata_i[fpt_pkg::BIT_OVF];
            if (cmp_a_sync[fpt_pkg::FLAG_SYNC_CYC-1]) begin
                cmp_a_flag <= 1'b1;
            end else if (cmp_a_clr_pend || cmp_a_vec_ack_i) begin
                cmp_a_flag <= 1'b0;
            end
            if (ovf_pend) begin
                ovf_flag <= 1'b1;
            end else if (ovf_clr_pend || ovf_vec_ack_i) begin
                ovf_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt requests and read port.
    logic [7:0] rd_mux;
    assign rd_mux = sel_ctrl ? timer_ctrl_reg
                  : sel_gen ? 8'h00
                  : sel_cnt ? count_value
                  : sel_cmpa ? cmp_a_buf
                  : sel_top ? cmp_top_value
                  : sel_mask ? {1'b0, cmp_a_irq_en, 3'b000, ovf_irq_en, 2'b00}
                  : sel_flag ? {1'b0, cmp_a_flag, 3'b000, ovf_flag, 2'b00}
                  : sel_pll ? {5'b00000, fast_clk_en, pll_on, 1'b0}
                  : 8'h00;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
            cmp_a_irq_o <= 1'b0;
            ovf_irq_o <= 1'b0;
            fast_clk_en_o <= 1'b0;
            pll_on_o <= 1'b0;
        end else begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
            cmp_a_irq_o <= cmp_a_flag && cmp_a_irq_en && global_irq_en_i;
            ovf_irq_o <= ovf_flag && ovf_irq_en && global_irq_en_i;
            fast_clk_en_o <= fast_clk_en;
            pll_on_o <= pll_on;
        end
    end
endmodule : fpt_timer

// *** tb/fpt_timer_props.sv ***
// Concurrent checks on the port behaviour of the fast PWM timer.
`timescale 1ns/1ps
module fpt_timer_props (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic fast_tick_i,
    input wire logic compat_mode_i,
    input wire logic port_pin_one_dir_i,
    input wire logic global_irq_en_i,
    input wire logic cmp_a_vec_ack_i,
    input wire logic ovf_vec_ack_i,
    input wire logic cmp_a_out_pin_o,
    input wire logic cmp_a_out_pin_oe_o,
    input wire logic cmp_a_irq_o,
    input wire logic ovf_irq_o,
    input wire logic fast_clk_en_o,
    input wire logic pll_on_o
);
    // All checks live in the one system clock domain.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    // A control write followed at once by its read-back.
    sequence s_ctrl_wr;
        wr_i && addr_i == fpt_pkg::OFS_TIMER_CTRL;
    endsequence
    sequence s_ctrl_rd;
        rd_i && !wr_i && addr_i == fpt_pkg::OFS_TIMER_CTRL;
    endsequence
    property p_ctrl_rb;
        s_ctrl_wr ##1 s_ctrl_rd |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("control read-back differs");
    property p_gen_rd;
        rd_i && addr_i == fpt_pkg::OFS_GENERAL_CTRL |=> rdata_o[2:1] == 2'b00;
    endproperty
    a_gen_rd: assert property (p_gen_rd) else $error("strobe bits read as one");
    property p_rsv_rd;
        rd_i && (addr_i == fpt_pkg::OFS_IRQ_MASK || addr_i == fpt_pkg::OFS_IRQ_FLAG)
            |=> !rdata_o[7] && !rdata_o[0];
    endproperty
    a_rsv_rd: assert property (p_rsv_rd) else $error("reserved mask or flag bit set");
    property p_pll_rsv;
        rd_i && addr_i == fpt_pkg::OFS_PLL_CTRL |=> rdata_o[6:3] == 4'h0;
    endproperty
    a_pll_rsv: assert property (p_pll_rsv) else $error("reserved PLL bit set");
    property p_compat;
        compat_mode_i |-> ##2 (fast_clk_en_o && pll_on_o);
    endproperty
    a_compat: assert property (p_compat) else $error("compat mode enables low");
    property p_oe_dir;
        cmp_a_out_pin_oe_o |-> $past(port_pin_one_dir_i);
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("pin driven with direction low");
    property p_cmp_irq;
        cmp_a_irq_o |-> $past(global_irq_en_i);
    endproperty
    a_cmp_irq: assert property (p_cmp_irq) else $error("compare request without gie");
    property p_ovf_irq;
        ovf_irq_o |-> $past(global_irq_en_i);
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request without gie");
    property p_cmp_ack;
        cmp_a_vec_ack_i |-> ##[1:3] !cmp_a_irq_o;
    endproperty
    a_cmp_ack: assert property (p_cmp_ack) else $error("compare request outlives ack");
    property p_ovf_ack;
        ovf_vec_ack_i |-> ##[1:3] !ovf_irq_o;
    endproperty
    a_ovf_ack: assert property (p_ovf_ack) else $error("overflow request outlives ack");
endmodule : fpt_timer_props

bind fpt_timer fpt_timer_props u_props (.clk_sys_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .fast_tick_i, .compat_mode_i, .port_pin_one_dir_i, .global_irq_en_i,
    .cmp_a_vec_ack_i, .ovf_vec_ack_i, .cmp_a_out_pin_o, .cmp_a_out_pin_oe_o, .cmp_a_irq_o,
    .ovf_irq_o, .fast_clk_en_o, .pll_on_o);

// *** tb/fpt_timer_bench.sv ***
// Self-checking bench for the fast PWM timer top.
`timescale 1ns/1ps
module fpt_timer_bench;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic fast_tick_i = 1'b1;
    logic compat_mode_i = 1'b0;
    logic port_pin_one_dir_i = 1'b1;
    logic global_irq_en_i = 1'b0;
    logic cmp_a_vec_ack_i = 1'b0;
    logic ovf_vec_ack_i = 1'b0;
    logic [7:0] rdata_o;
    logic cmp_a_out_pin_o, cmp_a_out_pin_oe_o, cmp_a_irq_o, ovf_irq_o, fast_clk_en_o, pll_on_o;
    int err_total = 0;
    int n_checks = 0;
    int ones = 0;
    logic [31:0] seed = 32'h95B5;
    logic [7:0] exp_q[$];
    logic [7:0] adr_q[$];
    logic rd_d = 1'b0;
    logic [1:0] acts[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    // The clock toggles every half period of 2 ns.
    always #2 clk_sys_i = ~clk_sys_i;
    fpt_timer uut (.clk_sys_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .fast_tick_i,
        .compat_mode_i, .port_pin_one_dir_i, .global_irq_en_i, .cmp_a_vec_ack_i, .ovf_vec_ack_i,
        .cmp_a_out_pin_o, .cmp_a_out_pin_oe_o, .cmp_a_irq_o, .ovf_irq_o, .fast_clk_en_o,
        .pll_on_o);
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
    endtask : wr
    // A read notes its expected value; the monitor compares it a cycle later.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        adr_q.push_back(a);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            wr_i <= 1'b0;
            rd_i <= 1'b0;
        end
    endtask : idle
    task automatic end_of_test;
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the strobe, so they are taken there.
    always @(posedge clk_sys_i) begin
        if (rd_d) begin
            chk(rdata_o, exp_q.pop_front(), $sformatf("reg %h", adr_q.pop_front()));
        end
        rd_d <= rd_i;
    end
    // A hang is cut short long after the sequence should have ended.
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_total++;
        end_of_test();
    end
    // Main sequence: registers, compare actions, flags, requests and PWM.
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(fpt_pkg::OFS_TIMER_CTRL, 8'h00);
        rd(fpt_pkg::OFS_CMP_TOP, 8'hFF);
        rd(fpt_pkg::OFS_COUNT, 8'h00);
        rd(8'h10, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(fpt_pkg::OFS_CMP_TOP, seed[7:0]);
            rd(fpt_pkg::OFS_CMP_TOP, seed[7:0]);
            wr(fpt_pkg::OFS_TIMER_CTRL, seed[23:16] & 8'hB0);
            rd(fpt_pkg::OFS_TIMER_CTRL, seed[23:16] & 8'hB0);
            wr(fpt_pkg::OFS_COUNT, seed[15:8]);
            idle(2);
            rd(fpt_pkg::OFS_COUNT, seed[15:8]);
        end
        wr(fpt_pkg::OFS_IRQ_MASK, 8'hC5);
        rd(fpt_pkg::OFS_IRQ_MASK, 8'h44);
        wr(fpt_pkg::OFS_PLL_CTRL, 8'h7E);
        rd(fpt_pkg::OFS_PLL_CTRL, 8'h06);
        wr(fpt_pkg::OFS_PLL_CTRL, 8'h00);
        wr(fpt_pkg::OFS_IRQ_MASK, 8'h00);
        compat_mode_i <= 1'b1;
        idle(3);
        chk({6'h00, fast_clk_en_o, pll_on_o}, 8'h03, "pll enables");
        compat_mode_i <= 1'b0;
        wr(fpt_pkg::OFS_GENERAL_CTRL, 8'h06);
        rd(fpt_pkg::OFS_GENERAL_CTRL, 8'h00);
        // Forced actions walk set, clear and two toggles with the timer stopped.
        for (int i = 0; i < 4; i++) begin
            wr(fpt_pkg::OFS_TIMER_CTRL, {2'b00, acts[i], 4'h0});
            wr(fpt_pkg::OFS_GENERAL_CTRL, 8'h04);
            idle(3);
            chk({6'h00, cmp_a_out_pin_oe_o, cmp_a_out_pin_o}, {7'h01, ~i[0]}, "pin");
        end
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h00);
        idle(3);
        chk({7'h00, cmp_a_out_pin_oe_o}, 8'h00, "pin enable off");
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h30);
        port_pin_one_dir_i <= 1'b0;
        idle(3);
        chk({7'h00, cmp_a_out_pin_oe_o}, 8'h00, "pin enable dir");
        port_pin_one_dir_i <= 1'b1;
        wr(fpt_pkg::OFS_COUNT, 8'h00);
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h70);
        wr(fpt_pkg::OFS_GENERAL_CTRL, 8'h04);
        idle(3);
        chk({7'h00, cmp_a_out_pin_o}, 8'h00, "pin pwm force");
        // Counting runs: software equality, clear on A, clear on top, free run.
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h00);
        wr(fpt_pkg::OFS_CMP_TOP, 8'hFF);
        wr(fpt_pkg::OFS_CMP_A, 8'h10);
        wr(fpt_pkg::OFS_IRQ_FLAG, 8'h44);
        wr(fpt_pkg::OFS_COUNT, 8'h10);
        idle(3);
        rd(fpt_pkg::OFS_IRQ_FLAG, 8'h00);
        wr(fpt_pkg::OFS_COUNT, 8'h00);
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h81);
        idle(300);
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h00);
        idle(4);
        rd(fpt_pkg::OFS_IRQ_FLAG, 8'h40);
        wr(fpt_pkg::OFS_IRQ_FLAG, 8'h44);
        wr(fpt_pkg::OFS_CMP_TOP, 8'h20);
        wr(fpt_pkg::OFS_CMP_A, 8'h80);
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h81);
        idle(300);
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h00);
        idle(4);
        rd(fpt_pkg::OFS_IRQ_FLAG, 8'h00);
        wr(fpt_pkg::OFS_CMP_TOP, 8'hFF);
        wr(fpt_pkg::OFS_CMP_A, 8'h10);
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h01);
        idle(300);
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h00);
        idle(4);
        rd(fpt_pkg::OFS_IRQ_FLAG, 8'h44);
        // Requests follow mask and global enable, and vector acks drop them.
        wr(fpt_pkg::OFS_IRQ_MASK, 8'h44);
        global_irq_en_i <= 1'b1;
        idle(3);
        chk({6'h00, cmp_a_irq_o, ovf_irq_o}, 8'h03, "requests on");
        global_irq_en_i <= 1'b0;
        idle(2);
        chk({6'h00, cmp_a_irq_o, ovf_irq_o}, 8'h00, "requests gated");
        global_irq_en_i <= 1'b1;
        cmp_a_vec_ack_i <= 1'b1;
        ovf_vec_ack_i <= 1'b1;
        idle(1);
        cmp_a_vec_ack_i <= 1'b0;
        ovf_vec_ack_i <= 1'b0;
        idle(3);
        chk({6'h00, cmp_a_irq_o, ovf_irq_o}, 8'h00, "requests acked");
        rd(fpt_pkg::OFS_IRQ_FLAG, 8'h00);
        // PWM with top 0F and compare 05: the duty sits near 5 or 6 of 16.
        wr(fpt_pkg::OFS_CMP_TOP, 8'h0F);
        wr(fpt_pkg::OFS_CMP_A, 8'h05);
        wr(fpt_pkg::OFS_COUNT, 8'h00);
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h61);
        idle(40);
        repeat (160) begin
            @(posedge clk_sys_i);
            ones += int'(cmp_a_out_pin_o);
        end
        chk({7'h00, ones >= 48 && ones <= 64}, 8'h01, "pwm duty");
        chk({7'h00, cmp_a_out_pin_oe_o}, 8'h01, "pwm enable");
        wr(fpt_pkg::OFS_CMP_A, 8'h0A);
        rd(fpt_pkg::OFS_CMP_A, 8'h0A);
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h00);
        rd(fpt_pkg::OFS_IRQ_FLAG, 8'h44);
        // Cpu clock over eight after a prescaler clear: nine ticks fit the window.
        wr(fpt_pkg::OFS_COUNT, 8'h00);
        wr(fpt_pkg::OFS_GENERAL_CTRL, 8'h02);
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h08);
        idle(75);
        wr(fpt_pkg::OFS_TIMER_CTRL, 8'h00);
        idle(2);
        rd(fpt_pkg::OFS_COUNT, 8'h09);
        idle(4);
        end_of_test();
    end
endmodule : fpt_timer_bench
